// File: core/clkdelay_pkg.sv
// Shared constants, register map and helper functions for the sample clock block
package clkdelay_pkg;
  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DELAY_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;

  // ==========================================================================
  // Control register fields
  localparam int CTRL_MARK_BIT = 0;
  localparam int CTRL_SINGLE_BIT = 1;
  localparam int CTRL_EIGHT_BIT = 2;
  localparam int CTRL_LINK_LSB = 8;
  localparam int LINK_MODE_W = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // ==========================================================================
  // Delay register fields
  localparam int DLY_INV_BIT = 0;
  localparam int DLY_COARSE_LSB = 8;
  localparam int DLY_FINE_LSB = 16;
  localparam int DLY_RAMP_EN_BIT = 24;
  localparam int DLY_RAMP_FAST_BIT = 25;
  localparam int CODE_W = 8;
  localparam logic [31:0] DELAY_RESET = 32'h0000_0000;

  // ==========================================================================
  // Status register fields
  localparam int STS_COARSE_LSB = 0;
  localparam int STS_BUSY_BIT = 8;
  localparam int STS_MARK_BIT = 9;
  localparam int STS_DECIM_BIT = 10;

  // ==========================================================================
  // Timing and data constants
  localparam int RAMP_PERIOD_CYC = 256;
  localparam logic [7:0] RAMP_SLOW_STEP = 8'h01;
  localparam logic [7:0] RAMP_FAST_STEP = 8'h04;
  localparam logic [4:0] LINK_DECIM_FIRST = 5'h09;
  localparam int SAMPLE_W = 12;
  localparam int NARROW_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Merge a bus write into a register honouring the byte strobes
  function automatic logic [31:0] apply_strobe(input logic [31:0] old,
                                                input logic [31:0] data,
                                                input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strobe

  // Put the trigger state into the least significant bit of an output word
  function automatic logic [SAMPLE_W-1:0] insert_marker(input logic [SAMPLE_W-1:0] w,
                                                       input logic t,
                                                       input logic on,
                                                       input logic eight);
    logic [SAMPLE_W-1:0] res;
    res = w;
    if (on && eight) begin
      res = {{(SAMPLE_W-NARROW_W){1'b0}}, w[SAMPLE_W-1 -: NARROW_W-1], t};
    end else if (on) begin
      res = {w[SAMPLE_W-1:1], t};
    end
    return res;
  endfunction : insert_marker
endpackage : clkdelay_pkg

// File: core/coarse_ramp.sv
// Coarse delay ramp: walks the applied code toward the written target
module coarse_ramp
  import clkdelay_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  delay_ctl_if.ramp dc
);
  logic [7:0] div_q, div_d;
  logic [7:0] applied_q, applied_d;
  logic [7:0] target_q, target_d;
  logic [7:0] step;
  logic tick;

  // ==========================================================================
  // Free-running divider, one enable pulse every period
  assign tick = (div_q == 8'(RAMP_PERIOD_CYC - 1));
  assign step = dc.fast ? RAMP_FAST_STEP : RAMP_SLOW_STEP;

  always_comb begin
    div_d = div_q + 8'h01;
    target_d = target_q;
    applied_d = applied_q;
    if (dc.wr) begin
      target_d = dc.target;
      if (!dc.ramp_en) begin
        applied_d = dc.target;
      end
    end else if (!dc.ramp_en) begin
      // Ramp turned off mid-way: land on target at once
      applied_d = target_q;
    end else if (tick && applied_q != target_q) begin
      if (target_q > applied_q) begin
        applied_d = (target_q - applied_q > step) ? applied_q + step : target_q;
      end else begin
        applied_d = (applied_q - target_q > step) ? applied_q - step : target_q;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 8'h00;
      applied_q <= DELAY_RESET[DLY_COARSE_LSB +: CODE_W];
      target_q <= DELAY_RESET[DLY_COARSE_LSB +: CODE_W];
    end else begin
      div_q <= div_d;
      applied_q <= applied_d;
      target_q <= target_d;
    end
  end

  assign dc.applied = applied_q;
  assign dc.busy = (applied_q != target_q);

  // ==========================================================================
  // Checks
  a_tick_period: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |-> ##256 tick) else $error("ramp divider period wrong");
  a_slow_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && dc.ramp_en && !dc.fast && !dc.wr && dc.busy)
    |=> (applied_q == $past(applied_q) + 8'h01) || (applied_q == $past(applied_q) - 8'h01))
    else $error("slow ramp did not move one code");
  a_ramp_holds_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (!dc.busy && dc.ramp_en && !dc.wr) |=> $stable(applied_q))
    else $error("applied code moved at target");
  a_direct_no_ramp: assert property (@(posedge aclk) disable iff (!aresetn)
    (dc.wr && !dc.ramp_en) |=> applied_q == $past(dc.target))
    else $error("code not applied directly");
endmodule : coarse_ramp

// File: core/delay_ctl_if.sv
// Carrier between the register file and the coarse delay ramp
interface delay_ctl_if;
  logic wr;
  logic [7:0] target;
  logic ramp_en;
  logic fast;
  logic [7:0] applied;
  logic busy;
  modport ramp (input wr, input target, input ramp_en, input fast,
                output applied, output busy);
  modport ctl (output wr, output target, output ramp_en, output fast,
               input applied, input busy);
endinterface : delay_ctl_if

// File: core/marker_pipe.sv
// Converter data and trigger pipeline with matched latency
module marker_pipe
  import clkdelay_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [SAMPLE_W-1:0] in_a,
  input wire logic [SAMPLE_W-1:0] in_b,
  input wire logic in_trig,
  output logic [SAMPLE_W-1:0] out_a,
  output logic [SAMPLE_W-1:0] out_b,
  output logic out_trig
);
  if (DEPTH < 1) begin : g_bad_depth
    $error("marker_pipe DEPTH must be at least 1");
  end

  logic [SAMPLE_W-1:0] a_q [DEPTH];
  logic [SAMPLE_W-1:0] b_q [DEPTH];
  logic [DEPTH-1:0] t_q, t_d;
  logic [SAMPLE_W-1:0] a_d [DEPTH];
  logic [SAMPLE_W-1:0] b_d [DEPTH];

  // ==========================================================================
  // equal latency paths
  always_comb begin
    t_d = DEPTH'({t_q, in_trig});
    a_d[0] = in_a;
    b_d[0] = in_b;
    for (int i = 1; i < DEPTH; i++) begin
      a_d[i] = a_q[i-1];
      b_d[i] = b_q[i-1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        a_q[i] <= '0;
        b_q[i] <= '0;
      end
    end else begin
      t_q <= t_d;
      a_q <= a_d;
      b_q <= b_d;
    end
  end

  assign out_a = a_q[DEPTH-1];
  assign out_b = b_q[DEPTH-1];
  assign out_trig = t_q[DEPTH-1];

  a_trig_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, DEPTH) |-> out_trig == $past(in_trig, DEPTH))
    else $error("trigger latency differs from data");
  a_data_latency: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn, DEPTH) |-> out_a == $past(in_a, DEPTH))
    else $error("data latency wrong");
endmodule : marker_pipe

// File: core/sample_clock_delay_and_marker.sv
// Sample edge selection, trigger marker insertion and sampling delay control
//
// Function
// - Marker appears only while sample_marker_enable is set; otherwise plain data.
// - 12-bit modes: upper 11 converter bits plus trigger state in bit 0.
// - Trigger travels a 1-bit path with latency equal to the data path.
// - 8-bit modes: trigger state sits in the least significant bit.
// - Trigger may be asynchronous; sampled alongside the analog input.
// - No marker while a decimating link mode is selected.
// - One device clock drives sampling, processing and serial outputs.
// - Dual-channel mode samples each input once per clock, rising edge.
// - Single-channel mode samples on both edges, doubling the rate.
// - SYSREF is captured on a deterministic device clock edge.
// - Half-period invert flips the device clock, delaying sampling half a period.
// - Coarse and fine codes have 256 settings; all three delays combine freely.
// - Programmed delay shifts every internal clock, serial and SYSREF timing too.
// - Delay settings may change during operation; ramp lowers link upset risk.
// - With ramp active, applied coarse code moves gradually toward the target.
// - Ramp speed: slow one step, fast four steps per 256 cycles.
// - With ramp enabled, each coarse code write starts a new ramp.
module sample_clock_delay_and_marker
  import clkdelay_pkg::*;
#(
  parameter int PIPE_DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [SAMPLE_W-1:0] conv_word_a,
  input wire logic [SAMPLE_W-1:0] conv_word_b,
  input wire logic trigger_marker_input,
  input wire logic sysref_in,
  output logic [SAMPLE_W-1:0] out_word_a,
  output logic [SAMPLE_W-1:0] out_word_b,
  output logic dual_edge_sampling,
  output logic delay_half_period_invert,
  output logic [CODE_W-1:0] delay_coarse_code,
  output logic [CODE_W-1:0] delay_fine_code,
  output logic sysref_capture
);
  // ==========================================================================
  // Declarations
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] delay_q, delay_d;
  logic ramp_wr_q, ramp_wr_d;
  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [7:0] waddr_q, waddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic [SAMPLE_W-1:0] out_a_q, out_a_d;
  logic [SAMPLE_W-1:0] out_b_q, out_b_d;
  logic sysref_q, cap_q, cap_d;
  logic [SAMPLE_W-1:0] pipe_a, pipe_b;
  logic pipe_trig;
  logic decim_on, mark_on, do_write;
  logic [31:0] status_word;

  delay_ctl_if dc ();

  // ==========================================================================
  // Mode decode
  assign decim_on = (ctrl_q[CTRL_LINK_LSB +: LINK_MODE_W] >= LINK_DECIM_FIRST);
  assign mark_on = ctrl_q[CTRL_MARK_BIT] && !decim_on;

  // Read-only status view of the block's own state
  always_comb begin
    status_word = '0;
    status_word[STS_COARSE_LSB +: CODE_W] = dc.applied;
    status_word[STS_BUSY_BIT] = dc.busy;
    status_word[STS_MARK_BIT] = mark_on;
    status_word[STS_DECIM_BIT] = decim_on;
  end

  // ==========================================================================
  // AXI4-Lite slave: address and data taken in either order, answered once both held
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    delay_d = delay_q;
    ramp_wr_d = 1'b0;
    if (awvalid && awready_q) begin
      aw_hold_d = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = wdata;
      wstrb_d = wstrb;
    end
    if (bvalid_q && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (waddr_q)
        CTRL_OFS: begin
          ctrl_d = apply_strobe(ctrl_q, wdata_q, wstrb_q);
        end
        DELAY_OFS: begin
          delay_d = apply_strobe(delay_q, wdata_q, wstrb_q);
          ramp_wr_d = wstrb_q[DLY_COARSE_LSB / 8];
        end
        STATUS_OFS: begin
          bresp_d = RESP_OKAY;
        end
        default: begin
          bresp_d = RESP_SLVERR;
        end
      endcase
    end
    // Ready only while nothing of that kind is held, so payloads are never overwritten
    awready_d = !aw_hold_d && !bvalid_d;
    wready_d = !w_hold_d && !bvalid_d;
  end

  // Keep only defined bits; the rest read back as zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      delay_q <= DELAY_RESET;
      ramp_wr_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      ctrl_q <= ctrl_d & 32'h0000_1f07;
      delay_q <= delay_d & 32'h03ff_ff01;
      ramp_wr_q <= ramp_wr_d;
    end
  end

  // Read channel: one read at a time, data one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && rready) begin
      rvalid_d = 1'b0;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (araddr)
        CTRL_OFS: rdata_d = ctrl_q;
        DELAY_OFS: rdata_d = delay_q;
        STATUS_OFS: rdata_d = status_word;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      arready_q <= arready_d;
    end
  end

  // ==========================================================================
  // Delay control: coarse through the ramp, invert and fine straight through
  assign dc.wr = ramp_wr_q;
  assign dc.target = delay_q[DLY_COARSE_LSB +: CODE_W];
  assign dc.ramp_en = delay_q[DLY_RAMP_EN_BIT];
  assign dc.fast = delay_q[DLY_RAMP_FAST_BIT];

  coarse_ramp u_ramp (
    .aclk(aclk),
    .aresetn(aresetn),
    .dc(dc.ramp)
  );

  // ==========================================================================
  // Data path, all on the single device clock
  // trigger sampled with data
  marker_pipe #(
    .DEPTH(PIPE_DEPTH)
  ) u_pipe (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_a(conv_word_a),
    .in_b(conv_word_b),
    .in_trig(trigger_marker_input),
    .out_a(pipe_a),
    .out_b(pipe_b),
    .out_trig(pipe_trig)
  );

  always_comb begin
    out_a_d = insert_marker(pipe_a, pipe_trig, mark_on, ctrl_q[CTRL_EIGHT_BIT]);
    out_b_d = insert_marker(pipe_b, pipe_trig, mark_on, ctrl_q[CTRL_EIGHT_BIT]);
    cap_d = sysref_in && !sysref_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_a_q <= '0;
      out_b_q <= '0;
      sysref_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
      sysref_q <= sysref_in;
      cap_q <= cap_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign out_word_a = out_a_q;
  assign out_word_b = out_b_q;
  assign dual_edge_sampling = ctrl_q[CTRL_SINGLE_BIT];
  assign delay_half_period_invert = delay_q[DLY_INV_BIT];
  assign delay_fine_code = delay_q[DLY_FINE_LSB +: CODE_W];
  assign delay_coarse_code = dc.applied;
  assign sysref_capture = cap_q;

  // ==========================================================================
  // Checks
  a_marker_lsb_out: assert property (@(posedge aclk) disable iff (!aresetn)
    mark_on |=> out_a_q[0] == $past(pipe_trig) && out_b_q[0] == $past(pipe_trig))
    else $error("marker bit missing from output");
  a_raw_when_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !mark_on |=> out_a_q == $past(pipe_a) && out_b_q == $past(pipe_b))
    else $error("output altered with marker off");
  a_eight_bit_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    (mark_on && ctrl_q[CTRL_EIGHT_BIT]) |=> out_a_q[SAMPLE_W-1:NARROW_W] == '0)
    else $error("eight-bit word wider than eight bits");
  a_decim_no_mark: assert property (@(posedge aclk) disable iff (!aresetn)
    decim_on |-> !mark_on && !status_word[STS_MARK_BIT])
    else $error("marker active in decimating mode");
  a_sysref_one_edge: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sysref_in) |=> cap_q ##1 !cap_q)
    else $error("sysref capture not a single pulse");
  a_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid_q && !bready) |=> bvalid_q && $stable(bresp_q))
    else $error("write response dropped early");
endmodule : sample_clock_delay_and_marker

// File: verif/clk_source_model.sv
// Far-side model: converter sample source, trigger and SYSREF generator
module clk_source_model
  import clkdelay_pkg::*;
#(
  parameter int SR_PERIOD = 40
) (
  input wire logic aclk,
  input wire logic sr_periodic,
  input wire logic sr_fire,
  output logic [SAMPLE_W-1:0] conv_word_a,
  output logic [SAMPLE_W-1:0] conv_word_b,
  output logic trigger_marker_input,
  output logic sysref_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q = 16'h0000;
  logic [7:0] ph_q = 8'h00;
  logic [2:0] hi_q = 3'h0;
  // ==========================================================================
  // Stimulus streams
  // Distinct word streams so a swapped channel shows
  assign conv_word_a = 12'(cnt_q * 16'h0025);
  assign conv_word_b = 12'(cnt_q * 16'h005b + 16'h0007);
  assign trigger_marker_input = cnt_q[0] ^ cnt_q[3] ^ cnt_q[6];
  assign sysref_in = (sr_periodic && ph_q < 8'h04) || hi_q != 3'h0;
  // Everything moves just after the rising edge
  always @(posedge aclk) begin
    cnt_q <= cnt_q + 16'h0001;
    ph_q <= (ph_q == 8'(SR_PERIOD - 1)) ? 8'h00 : ph_q + 8'h01;
    hi_q <= sr_fire ? 3'h4 : (hi_q != 3'h0) ? hi_q - 3'h1 : 3'h0;
  end
endmodule : clk_source_model

// File: verif/test_sample_clock_delay_and_marker.sv
// Bench for marker insertion, edge mode and delay ramp over AXI4-Lite
module test_sample_clock_delay_and_marker import clkdelay_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PD = 4;
  localparam int LIMIT = 6000;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, trig, sysref_in, sysref_capture;
  logic dual_edge, inv, sr_periodic, sr_fire, sr_prev;
  logic [7:0] awaddr, araddr, coarse, fine;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [SAMPLE_W-1:0] ca, cb, oa, ob;
  logic [11:0] ha [16];
  logic [11:0] hb [16];
  logic ht [16];
  logic chk_on = 1'b0;
  logic m_on = 1'b0;
  logic m_eight = 1'b0;
  logic [31:0] ctab [7] = '{32'h0, 32'h1, 32'h5, 32'h3, 32'h0801, 32'h0901, 32'h1f05};
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int sr_rises = 0;
  int sr_caps = 0;

  always #2 aclk = ~aclk;

  sample_clock_delay_and_marker #(.PIPE_DEPTH(PD)) uut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .conv_word_a(ca), .conv_word_b(cb),
    .trigger_marker_input(trig), .sysref_in(sysref_in), .out_word_a(oa), .out_word_b(ob),
    .dual_edge_sampling(dual_edge), .delay_half_period_invert(inv),
    .delay_coarse_code(coarse), .delay_fine_code(fine), .sysref_capture(sysref_capture));

  clk_source_model #(.SR_PERIOD(40)) src (.aclk(aclk), .sr_periodic(sr_periodic),
    .sr_fire(sr_fire), .conv_word_a(ca), .conv_word_b(cb), .trigger_marker_input(trig),
    .sysref_in(sysref_in));

  // ==========================================================================
  // Checking helpers
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h got %h", nm, exp, got);
    end
  endtask : check

  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Expected word: data with the trigger folded into bit 0 when active
  function automatic logic [11:0] mark_word(input logic [11:0] w, input logic t);
    if (!m_on) return w;
    if (m_eight) return {4'h0, w[11:5], t};
    return {w[11:1], t};
  endfunction : mark_word

  // ==========================================================================
  // Bus master
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Handshake edge is the one that shows bvalid high
    while (bvalid !== 1'b1) @(posedge aclk);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    // Look at arready only at edges where arvalid already stands
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    axi_read(a);
    check("read data", exp, rd);
    check("read resp", 32'(er), 32'(rs));
  endtask : rd_chk

  // Measures how long the applied coarse code waits before its next move
  task automatic step_chk(input logic [7:0] exp, input int gap);
    int n;
    logic [7:0] prev;
    n = 0;
    prev = coarse;
    while (coarse === prev && n < 300) begin
      @(posedge aclk);
      n++;
    end
    check("coarse step", 32'(exp), 32'(coarse));
    if (gap > 0) check("step gap", 32'(gap), 32'(n));
  endtask : step_chk

  // ==========================================================================
  // Output monitor: data path against history, SYSREF tally, timeout
  always @(posedge aclk) begin : mon
    int k;
    k = (cyc - PD - 1) & 15;
    if (chk_on) begin
      check("out_word_a", 32'(mark_word(ha[k], ht[k])), 32'(oa));
      check("out_word_b", 32'(mark_word(hb[k], ht[k])), 32'(ob));
    end
    ha[cyc & 15] = ca;
    hb[cyc & 15] = cb;
    ht[cyc & 15] = trig;
    if (sysref_in && !sr_prev) sr_rises++;
    if (sysref_capture) sr_caps++;
    sr_prev = sysref_in;
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sr_periodic, sr_fire} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    sr_prev = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(CTRL_OFS, CTRL_RESET, RESP_OKAY);
    rd_chk(DELAY_OFS, DELAY_RESET, RESP_OKAY);
    rd_chk(8'h0c, 32'h0, RESP_SLVERR);
    axi_write(8'h0c, 32'hffff_ffff, 4'hf);
    check("unmapped write resp", 32'(RESP_SLVERR), 32'(rs));
    axi_write(STATUS_OFS, 32'hffff_ffff, 4'hf);
    rd_chk(STATUS_OFS, 32'h0, RESP_OKAY);
    // Every marker and channel mode, with a SYSREF pulse each
    for (int i = 0; i < 7; i++) begin
      chk_on <= 1'b0;
      axi_write(CTRL_OFS, ctab[i], 4'hf);
      m_on <= ctab[i][0] && ctab[i][12:8] < 5'h09;
      m_eight <= ctab[i][2];
      sr_fire <= 1'b1;
      @(posedge aclk);
      sr_fire <= 1'b0;
      repeat (PD + 3) @(posedge aclk);
      chk_on <= 1'b1;
      repeat (24) @(posedge aclk);
      chk_on <= 1'b0;
      check("dual_edge_sampling", 32'(ctab[i][1]), 32'(dual_edge));
      rd_chk(STATUS_OFS, {21'h0, ctab[i][12:8] > 5'h08, m_on, 9'h0}, RESP_OKAY);
    end
    // Direct settings, then a byte-lane update of the fine code only
    sr_periodic <= 1'b1;
    axi_write(DELAY_OFS, 32'h00a5_ff01, 4'hf);
    repeat (4) @(posedge aclk);
    check("invert", 32'h1, 32'(inv));
    check("coarse jump", 32'hff, 32'(coarse));
    check("fine", 32'ha5, 32'(fine));
    axi_write(DELAY_OFS, 32'h0033_0000, 4'h4);
    rd_chk(DELAY_OFS, 32'h0033_ff01, RESP_OKAY);
    // Slow ramp down two codes, then a fast ramp that clamps at the target
    // Divider runs free and may tick right after the write, so watch from the return
    axi_write(DELAY_OFS, 32'h0100_fd00, 4'hf);
    step_chk(8'hfe, 0);
    check("invert direct", 32'h0, 32'(inv));
    check("fine direct", 32'h0, 32'(fine));
    step_chk(8'hfd, 256);
    axi_write(DELAY_OFS, 32'h0300_f400, 4'hf);
    step_chk(8'hf9, 0);
    step_chk(8'hf5, 256);
    step_chk(8'hf4, 256);
    repeat (300) @(posedge aclk);
    check("coarse settled", 32'hf4, 32'(coarse));
    rd_chk(STATUS_OFS, 32'h0000_04f4, RESP_OKAY);
    sr_periodic <= 1'b0;
    repeat (10) @(posedge aclk);
    check("sysref captures", 32'(sr_rises), 32'(sr_caps));
    stop_test();
  end
endmodule : test_sample_clock_delay_and_marker
